// ### src/module_interrupt_reset_control.sv
`timescale 1ns/100ps
module module_interrupt_reset_control #(
  parameter longint     RESET_MIN_CYC = ctl_pkg::RESET_MIN_CYC,
  parameter longint     INIT_CYC      = ctl_pkg::INIT_MAX_CYC,
  parameter logic [6:0] DEV_ADDR      = 7'h50  // arbitrary value
) (
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe_out,
  input  wire logic [7:0] event_in,
  output logic            module_present_n_out,
  output logic            lanes_off_out,
  output logic [7:0]      settings_out,
  output logic            ready_out
);
  import ctl_pkg::*;

  // ==========================================================
  // elaboration checks
  if (INT_PULSE_CYC < INT_MIN_CYC || INT_PULSE_CYC > INT_MAX_CYC)
    $error("interrupt pulse out of range");
  if (RESET_MIN_CYC <= INT_MAX_CYC || RESET_MIN_CYC > 64'hffff_ffff)
    $error("reset width must exceed interrupt width");
  if (INIT_CYC < 1 || INIT_CYC > INIT_MAX_CYC)
    $error("init time out of range");

  localparam logic [31:0] RST_LAST   = 32'(RESET_MIN_CYC - 1);
  localparam logic [31:0] INIT_LAST  = 32'(INIT_CYC - 1);
  localparam logic [11:0] PULSE_LAST = 12'(INT_PULSE_CYC - 1);
  localparam logic [4:0]  HOLD_LOAD  = 5'(HOLDOFF_CYC);

  // ==========================================================
  // serial port
  mgmt_if mif ();

  two_wire_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_oe_out  (sda_oe_out),
    .bus         (mif.port)
  );

  // ==========================================================
  // shared line synchroniser and own-drive blanking
  logic        line_s1_r, line_s2_r;
  logic [4:0]  hold_r;
  rst_state_t  state_r;
  logic [31:0] low_cnt_r, init_cnt_r;
  logic [11:0] pulse_cnt_r;
  logic [7:0]  ctrl_r, flags_r, ev_d_r, rd_data_r;
  logic        not_ready_r, int_flag_r, pending_r, port_en_r;

  always_ff @(posedge core_clk_in) begin
    line_s1_r <= line_in;
    line_s2_r <= line_s1_r;
  end

  // a low seen while we pull, or just after, is our own pulse
  wire host_low = ~line_s2_r & ~line_oe_out & (hold_r == 5'h00);

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      hold_r <= 5'h00;
    end else if (line_oe_out) begin
      hold_r <= HOLD_LOAD;
    end else if (hold_r != 5'h00) begin
      hold_r <= 5'(hold_r - 5'h01);
    end
  end

  // ==========================================================
  // reset and init sequencing
  wire rst_hit   = (state_r == ST_RUN) && host_low &&
                   (low_cnt_r == RST_LAST);
  wire init_done = (state_r == ST_INIT) && (init_cnt_r == INIT_LAST);

  // lows during init are not watched, as the line may still settle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r    <= ST_INIT;
      low_cnt_r  <= 32'h0;
      init_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        ST_INIT: begin
          init_cnt_r <= 32'(init_cnt_r + 32'h1);
          if (init_done) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          low_cnt_r <= host_low ? 32'(low_cnt_r + 32'h1) : 32'h0;
          if (rst_hit) begin
            state_r <= ST_HOST_RST;
          end
        end
        ST_HOST_RST: begin
          low_cnt_r  <= 32'h0;
          init_cnt_r <= 32'h0;
          if (line_s2_r) begin
            state_r <= ST_INIT;
          end
        end
        default: state_r <= ST_INIT;
      endcase
    end
  end

  // ==========================================================
  // register bank, events and flags
  wire [7:0] ev_new     = event_in & ~ev_d_r & {8{state_r == ST_RUN}};
  wire       flags_rd   = mif.rd_stb && (mif.ptr == REG_FLAGS);
  wire       ctrl_wr    = mif.wr_stb && (mif.ptr == REG_CTRL);
  wire       int_cause  = (|ev_new) | init_done;
  wire [7:0] flags_nxt  = (flags_r & ~{8{flags_rd}}) | ev_new;
  wire       int_fl_nxt = (int_flag_r & ~flags_rd) | int_cause;
  wire [7:0] status_w   = {6'h00, int_flag_r, not_ready_r};
  wire [7:0] rd_mux_w   = (mif.ptr == REG_STATUS) ? status_w :
                          (mif.ptr == REG_FLAGS)  ? flags_r  :
                          (mif.ptr == REG_CTRL)   ? ctrl_r   : 8'h00;
  wire       pulse_go   = (state_r == ST_RUN) && pending_r &&
                          !line_oe_out && (hold_r == 5'h00);

  assign mif.enable  = port_en_r;
  assign mif.rd_data = rd_data_r;

  // a flag raised in the cycle it is read stays set
  always_ff @(posedge core_clk_in) begin
    ev_d_r    <= srst_in ? 8'h00 : event_in;
    rd_data_r <= srst_in ? 8'h00 : rd_mux_w;
    if (srst_in || state_r == ST_HOST_RST) begin
      ctrl_r      <= CTRL_RST;
      flags_r     <= 8'h00;
      not_ready_r <= 1'b1;
      int_flag_r  <= 1'b0;
      pending_r   <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_wr ? mif.wr_data : ctrl_r;
      flags_r     <= flags_nxt;
      int_flag_r  <= int_fl_nxt;
      not_ready_r <= not_ready_r & ~init_done;
      pending_r   <= (pending_r & ~pulse_go) | int_cause;
    end
  end

  // ==========================================================
  // interrupt pulse driver and pin outputs
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      line_oe_out <= 1'b0;
      pulse_cnt_r <= 12'h000;
    end else if (pulse_go) begin
      line_oe_out <= 1'b1;
      pulse_cnt_r <= PULSE_LAST;
    end else if (line_oe_out) begin
      pulse_cnt_r <= 12'(pulse_cnt_r - 12'h001);
      if (pulse_cnt_r == 12'h000) begin
        line_oe_out <= 1'b0;
      end
    end
  end

  // open drain pins only ever pull low
  always_ff @(posedge core_clk_in) begin
    line_out             <= 1'b0;
    sda_out              <= 1'b0;
    module_present_n_out <= 1'b0;
    port_en_r            <= srst_in || (state_r != ST_HOST_RST);
    lanes_off_out        <= srst_in || (state_r == ST_HOST_RST) ||
                            ctrl_r[LANE_OFF_BIT];
    settings_out         <= srst_in ? CTRL_RST : ctrl_r;
    ready_out            <= ~srst_in & ~not_ready_r;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  logic [11:0] oe_len_r;
  always_ff @(posedge core_clk_in) begin
    oe_len_r <= (srst_in || !line_oe_out) ? 12'h000 : 12'(oe_len_r + 12'h1);
  end

  pulse_width_a : assert property (
    $fell(line_oe_out) |-> oe_len_r == 12'(INT_PULSE_CYC))
    else $error("interrupt pulse width wrong");
  pulse_max_a : assert property (
    line_oe_out |-> oe_len_r < 12'(INT_MAX_CYC))
    else $error("interrupt pulse too long");
  no_self_reset_a : assert property (
    line_oe_out |=> state_r != ST_HOST_RST)
    else $error("own pulse caused reset");
  reset_entry_a : assert property (
    rst_hit |=> state_r == ST_HOST_RST ##1 ctrl_r == CTRL_RST && not_ready_r)
    else $error("host reset not taken");
  reset_hold_a : assert property (
    (state_r == ST_HOST_RST && !line_s2_r) |=> state_r == ST_HOST_RST)
    else $error("reset left while line low");
  lanes_quiet_a : assert property (
    state_r == ST_HOST_RST |=> lanes_off_out && !mif.enable)
    else $error("lanes or port active in reset");
  init_start_a : assert property (
    (state_r == ST_HOST_RST && line_s2_r) |=>
      state_r == ST_INIT && init_cnt_r == 32'h0)
    else $error("init not timed from release");
  ready_irq_a : assert property (
    $fell(not_ready_r) |-> ##[0:1] $rose(line_oe_out))
    else $error("no completion interrupt");
  present_a : assert property (!module_present_n_out)
    else $error("presence not shown");
endmodule : module_interrupt_reset_control

// ### common/ctl_pkg.sv
// Notes on behaviour
// - sample data on scl rise, launch on fall
// - port is slave only, host starts transfers
// - shared line active low, open drain only
// - short low pulse from module means interrupt
// - interrupt is a pulse, line always released
// - host reads flags to find interrupt cause
// - long host low resets all user settings
// - host reset low may last any length
// - init time starts at reset release edge
// - completion interrupt after not-ready bit clears
// - power-up also posts completion interrupt
// - presence output low while module inserted
// - interrupt pulse between 5 and 50 us
// - operational within 2000 ms of reset
// - during host reset lanes off, port silent
package ctl_pkg;
  // ==========================================================
  // timing
  localparam longint CLK_HZ        = 40_000_000;
  localparam longint RESET_MIN_MS  = 25;
  localparam longint RESET_MIN_CYC = (RESET_MIN_MS * CLK_HZ + 999) / 1000;
  localparam longint INT_MIN_US    = 5;
  localparam longint INT_MIN_CYC   =
    (INT_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint INT_MAX_US    = 50;
  localparam longint INT_MAX_CYC   = INT_MAX_US * CLK_HZ / 1_000_000;
  localparam longint INT_PULSE_CYC = (INT_MIN_CYC + INT_MAX_CYC) / 2;
  localparam longint INIT_MAX_MS   = 2000;
  localparam longint INIT_MAX_CYC  = INIT_MAX_MS * CLK_HZ / 1000;
  // settling time of the pulled-up line after our own pulse
  localparam int     HOLDOFF_CYC   = 16;

  // ==========================================================
  // byte map of the serial port
  localparam logic [7:0] REG_STATUS    = 8'h02;
  localparam logic [7:0] REG_FLAGS     = 8'h03;
  localparam logic [7:0] REG_CTRL      = 8'h04;
  localparam int         NOT_READY_BIT = 0;
  localparam int         INT_FLAG_BIT  = 1;
  localparam int         LANE_OFF_BIT  = 0;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================
  // states
  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_HOST_RST} rst_state_t;
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_PTR, TW_WDATA, TW_ACK, TW_RDATA, TW_MACK
  } tw_state_t;
endpackage : ctl_pkg

// ### common/mgmt_if.sv
`timescale 1ns/100ps
// byte access between the serial port and the register bank
interface mgmt_if;
  logic       enable;
  logic [7:0] ptr;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       rd_stb;
  logic [7:0] rd_data;
  modport port (input enable, input rd_data,
                output ptr, output wr_stb, output wr_data, output rd_stb);
  modport regs (output enable, output rd_data,
                input ptr, input wr_stb, input wr_data, input rd_stb);
endinterface : mgmt_if

// ### src/two_wire_port.sv
`timescale 1ns/100ps
module two_wire_port #(
  parameter logic [6:0] DEV_ADDR = 7'h50  // arbitrary value
) (
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_out,
  mgmt_if.port      bus
);
  import ctl_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  always_ff @(posedge core_clk_in) begin
    scl_s1_r <= scl_in;
    scl_s2_r <= scl_s1_r;
    scl_d_r  <= scl_s2_r;
    sda_s1_r <= sda_in;
    sda_s2_r <= sda_s1_r;
    sda_d_r  <= sda_s2_r;
  end

  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire start_w  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop_w   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // ==========================================================
  // byte engine
  tw_state_t  state_r, after_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, ptr_r;
  logic       wr_stb_r, rd_stb_r, nack_r;
  wire        rx_state = (state_r == TW_ADDR) || (state_r == TW_PTR) ||
                         (state_r == TW_WDATA);
  wire        addr_hit = (sh_r[7:1] == DEV_ADDR);

  assign bus.ptr     = ptr_r;
  assign bus.wr_stb  = wr_stb_r;
  assign bus.wr_data = sh_r;
  assign bus.rd_stb  = rd_stb_r;

  // disabled port drops any transfer and lets sda float
  always_ff @(posedge core_clk_in) begin
    wr_stb_r <= 1'b0;
    rd_stb_r <= 1'b0;
    if (wr_stb_r || rd_stb_r) begin
      ptr_r <= 8'(ptr_r + 8'h01);
    end
    if (srst_in || !bus.enable) begin
      state_r    <= TW_IDLE;
      after_r    <= TW_IDLE;
      sda_oe_out <= 1'b0;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      nack_r     <= 1'b0;
      ptr_r      <= 8'h00;
    end else if (stop_w) begin
      state_r    <= TW_IDLE;
      sda_oe_out <= 1'b0;
    end else if (start_w) begin
      state_r    <= TW_ADDR;
      cnt_r      <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (scl_rise) begin
      if (rx_state) begin
        sh_r  <= {sh_r[6:0], sda_s2_r};
        cnt_r <= 4'(cnt_r + 4'h1);
      end
      if (state_r == TW_MACK) begin
        nack_r <= sda_s2_r;
      end
    end else if (scl_fall) begin
      case (state_r)
        TW_ADDR, TW_PTR, TW_WDATA: begin
          if (cnt_r == BITS_PER_BYTE) begin
            cnt_r      <= 4'h0;
            state_r    <= TW_ACK;
            sda_oe_out <= 1'b1;
            after_r    <= TW_WDATA;
            if (state_r == TW_ADDR) begin
              after_r <= sh_r[0] ? TW_RDATA : TW_PTR;
              if (!addr_hit) begin
                state_r    <= TW_IDLE;
                sda_oe_out <= 1'b0;
              end
            end else if (state_r == TW_PTR) begin
              ptr_r <= sh_r;
            end else begin
              wr_stb_r <= 1'b1;
            end
          end
        end
        TW_ACK, TW_MACK: begin
          if ((state_r == TW_ACK && after_r == TW_RDATA) ||
              (state_r == TW_MACK && !nack_r)) begin
            sh_r       <= bus.rd_data;
            sda_oe_out <= ~bus.rd_data[7];
            cnt_r      <= 4'h1;
            state_r    <= TW_RDATA;
            rd_stb_r   <= 1'b1;
          end else begin
            sda_oe_out <= 1'b0;
            state_r    <= (state_r == TW_ACK) ? after_r : TW_IDLE;
          end
        end
        TW_RDATA: begin
          if (cnt_r == BITS_PER_BYTE) begin
            sda_oe_out <= 1'b0;
            state_r    <= TW_MACK;
          end else begin
            sh_r       <= {sh_r[6:0], 1'b0};
            sda_oe_out <= ~sh_r[6];
            cnt_r      <= 4'(cnt_r + 4'h1);
          end
        end
        default: ;
      endcase
    end
  end

  // sda only moves on scl fall, start, stop, or when a frame is dropped
  sda_launch_a : assert property (@(posedge core_clk_in) disable iff (srst_in)
    $changed(sda_oe_out) |-> $past(scl_fall || stop_w || start_w ||
                                   !bus.enable))
    else $error("sda changed outside scl fall");
endmodule : two_wire_port

// ### bench/host_master_model.sv
`timescale 1ns/100ps
// ==========================================================
// host side: two-wire bus master and shared-line puller
module host_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out,
  output logic      line_pull_out
);
  // 8 clk per bit: slave launches under 3 clk after fall, low is 5
  localparam int PH = 3;

  // idle bus: scl driven high, sda and the shared line released to their pull-ups
  initial begin
    scl_out       = 1'b1;
    sda_pull_out  = 1'b0;
    line_pull_out = 1'b0;
  end

  task automatic ph();
    repeat (PH) @(negedge clk_in);
  endtask : ph

  // start or repeated start; the host opens every transfer
  task automatic start();
    sda_pull_out = 1'b0;
    ph();
    scl_out = 1'b1;
    ph();
    sda_pull_out = 1'b1;
    ph();
    scl_out = 1'b0;
    ph();
  endtask : start

  task automatic stop();
    sda_pull_out = 1'b1;
    ph();
    scl_out = 1'b1;
    ph();
    sda_pull_out = 1'b0;
    ph();
  endtask : stop

  // data changes only while scl is low, read at end of high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull_out = ~b;
    ph();
    scl_out = 1'b1;
    ph();
    r = sda_in;
    scl_out = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : bit_io

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, r);
  endtask : rbyte

  // long low is a reset; caller picks length against the minimum
  task automatic line_low(input int n);
    line_pull_out = 1'b1;
    repeat (n) @(negedge clk_in);
    line_pull_out = 1'b0;
  endtask : line_low

  // reset of open length: pull until told to let go
  task automatic line_hold(input logic on);
    line_pull_out = on;
  endtask : line_hold
endmodule : host_master_model

// ### bench/module_interrupt_reset_control_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  $display("mismatch %s expected %h seen %h", nm, ex, got); \
  num_errors++; end end
module module_interrupt_reset_control_tb;
  import ctl_pkg::*;
  // ==========================================================
  // signals and wiring
  localparam int RMIN = 3000; // must exceed the longest own pulse
  localparam int INIT = 50;
  logic clk = 1'b0, srst = 1'b1;
  logic scl, sda_pull, line_pull, sda_o, sda_oe, line_o, line_oe;
  logic present_n, lanes_off, ready, ack;
  logic [7:0] event_r = 8'h00, settings, d;
  wire sda  = ~(sda_oe | sda_pull);
  wire line = ~(line_oe | line_pull);
  int num_errors = 0, n_checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  module_interrupt_reset_control #(.RESET_MIN_CYC(RMIN), .INIT_CYC(INIT))
    i_module_interrupt_reset_control (
    .core_clk_in(clk), .srst_in(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .line_in(line),
    .line_out(line_o), .line_oe_out(line_oe), .event_in(event_r),
    .module_present_n_out(present_n), .lanes_off_out(lanes_off),
    .settings_out(settings), .ready_out(ready));

  host_master_model i_host_master_model (.clk_in(clk), .sda_in(sda),
    .scl_out(scl), .sda_pull_out(sda_pull), .line_pull_out(line_pull));

  // ==========================================================
  // shared helpers
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic reg_write(input logic [7:0] p, input logic [7:0] v);
    i_host_master_model.start();
    i_host_master_model.wbyte(8'ha0, ack);
    `CHK("addr_ack", 1'b1, ack)
    i_host_master_model.wbyte(p, ack);
    i_host_master_model.wbyte(v, ack);
    i_host_master_model.stop();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] p, output logic [7:0] v);
    i_host_master_model.start();
    i_host_master_model.wbyte(8'ha0, ack);
    i_host_master_model.wbyte(p, ack);
    i_host_master_model.start();
    i_host_master_model.wbyte(8'ha1, ack);
    `CHK("rd_ack", 1'b1, ack)
    i_host_master_model.rbyte(1'b0, v);
    i_host_master_model.stop();
  endtask : reg_read

  // pulse must come, pull the wire low, and end inside its window
  task automatic wait_int(input int lim);
    int i, w;
    i = 0;
    w = 0;
    while (line_oe !== 1'b1 && i < lim) begin
      @(negedge clk);
      i++;
    end
    `CHK("int_seen", 1'b1, line_oe)
    `CHK("line_low", 1'b0, line)
    while (line_oe === 1'b1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    `CHK("int_width", INT_PULSE_CYC, longint'(w))
    `CHK("released", 1'b1, line)
  endtask : wait_int

  task automatic wait_ready(input int lo, input int hi);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < hi + 10) begin
      @(negedge clk);
      n++;
    end
    `CHK("init_time", 1'b1, n >= lo && n <= hi)
  endtask : wait_ready

  // ==========================================================
  // scenarios
  task automatic t_power_up();
    wait_ready(INIT - 2, INIT + 4);
    wait_int(4);
    reg_read(REG_STATUS, d);
    `CHK("not_ready", 1'b0, d[NOT_READY_BIT])
  endtask : t_power_up

  task automatic t_settings();
    reg_write(REG_CTRL, 8'h05);
    `CHK("settings", 8'h05, settings)
    `CHK("lanes_off", 1'b1, lanes_off)
    reg_read(REG_CTRL, d);
    `CHK("ctrl_back", 8'h05, d)
    reg_write(REG_CTRL, 8'h04);
    `CHK("lanes_on", 1'b0, lanes_off)
    // another address must not be answered
    i_host_master_model.start();
    i_host_master_model.wbyte(8'h42, ack);
    i_host_master_model.stop();
    `CHK("foreign_ack", 1'b0, ack)
  endtask : t_settings

  task automatic t_event();
    event_r = 8'h04;
    wait_int(4);
    event_r = 8'h00;
    repeat (20) @(negedge clk);
    `CHK("no_self_rst", 8'h04, settings)
    `CHK("still_ready", 1'b1, ready)
    reg_read(REG_FLAGS, d);
    `CHK("cause", 8'h04, d)
    reg_read(REG_FLAGS, d);
    `CHK("cleared", 8'h00, d)
    // host joins our pulse; only its own share of the low may count
    event_r = 8'h08;
    while (line_oe !== 1'b1) @(negedge clk);
    event_r = 8'h00;
    i_host_master_model.line_low(int'(INT_PULSE_CYC) + RMIN - 500);
    repeat (10) @(negedge clk);
    `CHK("joined_low", 1'b1, ready)
    reg_read(REG_FLAGS, d);
    `CHK("joined_cause", 8'h08, d)
  endtask : t_event

  task automatic t_host_reset();
    i_host_master_model.line_low(RMIN - 400);
    repeat (10) @(negedge clk);
    `CHK("short_low", 8'h04, settings)
    `CHK("short_rdy", 1'b1, ready)
    // long low, well past the minimum, port probed meanwhile
    i_host_master_model.line_hold(1'b1);
    repeat (RMIN + 20) @(negedge clk);
    `CHK("rst_lanes", 1'b1, lanes_off)
    i_host_master_model.start();
    i_host_master_model.wbyte(8'ha0, ack);
    i_host_master_model.stop();
    `CHK("rst_silent", 1'b0, ack)
    repeat (1500) @(negedge clk);
    `CHK("rst_held", 1'b0, ready)
    i_host_master_model.line_hold(1'b0);
    repeat (4) @(negedge clk);
    `CHK("defaults", 8'h00, settings)
    wait_ready(INIT - 4, INIT + 8);
    wait_int(4);
    reg_read(REG_STATUS, d);
    `CHK("rst_status", 1'b0, d[NOT_READY_BIT])
  endtask : t_host_reset

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(negedge clk);
    `CHK("present", 1'b0, present_n)
    `CHK("rst_oe", 1'b0, line_oe)
    `CHK("rst_ready", 1'b0, ready)
    srst = 1'b0;
    t_power_up();
    t_settings();
    t_event();
    t_host_reset();
    `CHK("sda_drive", 1'b0, sda_o)
    `CHK("line_drive", 1'b0, line_o)
    test_done();
  end
endmodule : module_interrupt_reset_control_tb
